//--- inc/vtpi_pkg.sv
// Constants for the vector table and pin interrupt block
package vtpi_pkg;
  // Vector numbering, one word per entry
  localparam int NUM_VEC = 19;
  localparam int VEC_W = 5;
  localparam logic [4:0] VEC_RESET = 5'h00;
  localparam logic [4:0] VEC_EXT_A = 5'h01;
  localparam logic [4:0] VEC_PCHG = 5'h02;
  localparam logic [4:0] VEC_FT_MA = 5'h03;
  localparam logic [4:0] VEC_FT_MB = 5'h04;
  localparam logic [4:0] VEC_FT_OVF = 5'h05;
  localparam logic [4:0] VEC_GT_OVF = 5'h06;
  localparam logic [4:0] VEC_EXT_B = 5'h0D;
  localparam logic [4:0] VEC_GT_MA = 5'h0E;
  localparam logic [4:0] VEC_GT_MB = 5'h0F;
  localparam logic [4:0] VEC_CAPT = 5'h10;
  localparam logic [4:0] VEC_FT_MD = 5'h11;
  localparam logic [4:0] VEC_FAULT = 5'h12;
  localparam logic [4:0] VEC_LAST = 5'h12;
  // Vectors fed straight from peripheral request lines
  localparam logic [18:0] PERIPH_MASK = 19'h7DFF8;

  // Register addresses
  localparam logic [7:0] ADDR_CORE_CTRL = 8'h35;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h3B;
  localparam logic [7:0] ADDR_IRQ_FLAG = 8'h3A;
  localparam logic [7:0] ADDR_PC_MASK_LO = 8'h23;
  localparam logic [7:0] ADDR_PC_MASK_HI = 8'h22;

  // Field positions
  localparam int EN_B = 7;
  localparam int EN_A = 6;
  localparam int EN_PC_HI = 5;
  localparam int EN_PC_LO = 4;
  localparam int FLAG_B = 7;
  localparam int FLAG_A = 6;
  localparam int FLAG_PC = 5;
  localparam int PC_LO_GRP_FIRST = 8;
  localparam int PC_LO_GRP_LAST = 11;
  localparam int PC_PINS = 16;

  // Reset values and writable bits
  localparam logic [7:0] CORE_CTRL_RST = 8'h00;
  localparam logic [7:0] CORE_CTRL_WMASK = 8'h7B;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam logic [7:0] IRQ_EN_WMASK = 8'hF0;
  localparam logic [7:0] PC_MASK_LO_RST = 8'hC8;
  localparam logic [7:0] PC_MASK_HI_RST = 8'hFF;

  // Sense control encoding
  typedef enum logic [1:0] {
    SENSE_LOW = 2'h0,
    SENSE_ANY = 2'h1,
    SENSE_FALL = 2'h2,
    SENSE_RISE = 2'h3
  } vtpi_sense_e;
endpackage : vtpi_pkg

//--- hdl/vtpi_ctrl.sv
// Interrupt vector selection and external pin interrupt detection
`timescale 1ns/100ps
`default_nettype none
module vtpi_ctrl
  import vtpi_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Pins, asynchronous
  input wire logic ext_irq_a,
  input wire logic ext_irq_b,
  input wire logic [15:0] pin_change_inputs,
  input wire logic [3:0] reset_cause,
  // Core side
  input wire logic glob_irq_en,
  input wire logic io_clk_run,
  input wire logic irq_ack,
  output logic irq_req,
  output logic [4:0] irq_vec,
  output logic wake_req,
  // Peripheral side
  input wire logic [18:0] periph_req,
  output logic [18:0] periph_ack
);

  // Whole block state
  typedef struct packed {
    logic [1:0] ext_s1;
    logic [1:0] ext_s2;
    logic [1:0] ext_p;
    logic [15:0] pc_s1;
    logic [15:0] pc_s2;
    logic [15:0] pc_p;
    logic [3:0] rc_s1;
    logic [3:0] rc_s2;
    logic [3:0] rc_p;
    logic [7:0] core_ctrl;
    logic [7:0] irq_en;
    logic [15:0] pc_mask;
    logic flag_a;
    logic flag_b;
    logic flag_pc;
    logic rst_pend;
    logic [18:0] pend;
    logic irq_req;
    logic [4:0] irq_vec;
    logic [7:0] rdata;
    logic wake;
  } vtpi_state_s;

  vtpi_state_s st_r;
  vtpi_state_s st_nxt;
  logic [15:0] pc_grp_en;
  logic [15:0] pc_hit;
  logic trig_a;
  logic trig_b;
  logic [18:0] ack_hot;
  vtpi_sense_e sense_r;

  assign sense_r = vtpi_sense_e'(st_r.core_ctrl[1:0]);

  // Group enable per pin change input
  for (genvar i = 0; i < PC_PINS; i++) begin : g_pc
    if (i >= PC_LO_GRP_FIRST && i <= PC_LO_GRP_LAST) begin : g_lo
      assign pc_grp_en[i] = st_r.irq_en[EN_PC_LO];
    end else begin : g_hi
      assign pc_grp_en[i] = st_r.irq_en[EN_PC_HI];
    end
    assign pc_hit[i] = (st_r.pc_s2[i] ^ st_r.pc_p[i]) & st_r.pc_mask[i] & pc_grp_en[i];
  end

  // Edge triggers from sampled pins; pin direction plays no part
  always_comb begin
    trig_a = 1'b0;
    trig_b = 1'b0;
    unique case (sense_r)
      SENSE_ANY: begin
        trig_a = st_r.ext_s2[0] ^ st_r.ext_p[0];
        trig_b = st_r.ext_s2[1] ^ st_r.ext_p[1];
      end
      SENSE_FALL: begin
        trig_a = st_r.ext_p[0] & ~st_r.ext_s2[0];
        trig_b = st_r.ext_p[1] & ~st_r.ext_s2[1];
      end
      SENSE_RISE: begin
        trig_a = ~st_r.ext_p[0] & st_r.ext_s2[0];
        trig_b = ~st_r.ext_p[1] & st_r.ext_s2[1];
      end
      SENSE_LOW: begin
        trig_a = 1'b0;
        trig_b = 1'b0;
      end
    endcase
    trig_a = trig_a & io_clk_run;
    trig_b = trig_b & io_clk_run;
  end

  assign ack_hot = irq_ack ? (19'h00001 << st_r.irq_vec) : 19'h00000;

  // Next state
  always_comb begin
    logic lvl_a;
    logic lvl_b;
    logic wr_flag;
    st_nxt = st_r;
    lvl_a = 1'b0;
    lvl_b = 1'b0;
    wr_flag = reg_wr && (reg_addr == ADDR_IRQ_FLAG);
    // Two-stage sampling of every pin; edges look at stage two only
    st_nxt.ext_s1 = {ext_irq_b, ext_irq_a};
    st_nxt.ext_s2 = st_r.ext_s1;
    st_nxt.ext_p = st_r.ext_s2;
    st_nxt.pc_s1 = pin_change_inputs;
    st_nxt.pc_s2 = st_r.pc_s1;
    st_nxt.pc_p = st_r.pc_s2;
    st_nxt.rc_s1 = reset_cause;
    st_nxt.rc_s2 = st_r.rc_s1;
    st_nxt.rc_p = st_r.rc_s2;
    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CORE_CTRL: st_nxt.core_ctrl = reg_wdata & CORE_CTRL_WMASK;
        ADDR_IRQ_EN: st_nxt.irq_en = reg_wdata & IRQ_EN_WMASK;
        ADDR_PC_MASK_LO: st_nxt.pc_mask[7:0] = reg_wdata;
        ADDR_PC_MASK_HI: st_nxt.pc_mask[15:8] = reg_wdata;
        default: ;
      endcase
    end
    // Flags: clear by vector taken or write-one, then set wins
    if ((ack_hot[VEC_EXT_A]) || (wr_flag && reg_wdata[FLAG_A])) begin
      st_nxt.flag_a = 1'b0;
    end
    if ((ack_hot[VEC_EXT_B]) || (wr_flag && reg_wdata[FLAG_B])) begin
      st_nxt.flag_b = 1'b0;
    end
    if ((ack_hot[VEC_PCHG]) || (wr_flag && reg_wdata[FLAG_PC])) begin
      st_nxt.flag_pc = 1'b0;
    end
    if (trig_a) begin
      st_nxt.flag_a = 1'b1;
    end
    if (trig_b) begin
      st_nxt.flag_b = 1'b1;
    end
    // Pin change needs no I/O clock, so no run gating here
    if (|pc_hit) begin
      st_nxt.flag_pc = 1'b1;
    end
    // Level mode keeps both edge flags clear, including after a mode change
    if (st_nxt.core_ctrl[1:0] == SENSE_LOW) begin
      st_nxt.flag_a = 1'b0;
      st_nxt.flag_b = 1'b0;
    end
    // Any reset cause restarts at vector zero
    if (ack_hot[VEC_RESET]) begin
      st_nxt.rst_pend = 1'b0;
    end
    if (|(st_r.rc_s2 & ~st_r.rc_p)) begin
      st_nxt.rst_pend = 1'b1;
    end
    // Level requests follow the live pin; a vanished level asks nothing
    if (st_nxt.core_ctrl[1:0] == SENSE_LOW) begin
      lvl_a = ~st_nxt.ext_s2[0];
      lvl_b = ~st_nxt.ext_s2[1] & io_clk_run;
    end
    // Vector assembly; reset is not gated by the global enable
    st_nxt.pend = periph_req & PERIPH_MASK;
    st_nxt.pend[VEC_EXT_A] = (st_nxt.flag_a | lvl_a) & st_nxt.irq_en[EN_A];
    st_nxt.pend[VEC_PCHG] = st_nxt.flag_pc & (st_nxt.irq_en[EN_PC_HI] | st_nxt.irq_en[EN_PC_LO]);
    st_nxt.pend[VEC_EXT_B] = (st_nxt.flag_b | lvl_b) & st_nxt.irq_en[EN_B];
    st_nxt.pend = glob_irq_en ? st_nxt.pend : 19'h00000;
    st_nxt.pend[VEC_RESET] = st_nxt.rst_pend;
    // Lowest address wins: scan downward so the last hit is the lowest
    st_nxt.irq_req = |st_nxt.pend;
    st_nxt.irq_vec = VEC_RESET;
    for (int v = NUM_VEC - 1; v >= 0; v--) begin
      if (st_nxt.pend[v]) begin
        st_nxt.irq_vec = 5'(v);
      end
    end
    // Wake only matters while the I/O clock is stopped
    st_nxt.wake = ~io_clk_run & ((|pc_hit) | (lvl_a & st_nxt.irq_en[EN_A]));
    // Read data one cycle after the strobe; holes read zero
    st_nxt.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CORE_CTRL: st_nxt.rdata = st_r.core_ctrl;
        ADDR_IRQ_EN: st_nxt.rdata = st_r.irq_en;
        ADDR_IRQ_FLAG: st_nxt.rdata = {st_r.flag_b, st_r.flag_a, st_r.flag_pc, 5'h00};
        ADDR_PC_MASK_LO: st_nxt.rdata = st_r.pc_mask[7:0];
        ADDR_PC_MASK_HI: st_nxt.rdata = st_r.pc_mask[15:8];
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= '0;
      // External and pin change samplers keep following the pins through reset, so an idle-high pin shows no false edge on release; reset-cause samplers clear
      st_r.ext_s1 <= st_nxt.ext_s1;
      st_r.ext_s2 <= st_nxt.ext_s2;
      st_r.ext_p <= st_nxt.ext_p;
      st_r.pc_s1 <= st_nxt.pc_s1;
      st_r.pc_s2 <= st_nxt.pc_s2;
      st_r.pc_p <= st_nxt.pc_p;
      st_r.core_ctrl <= CORE_CTRL_RST;
      st_r.irq_en <= IRQ_EN_RST;
      st_r.pc_mask <= {PC_MASK_HI_RST, PC_MASK_LO_RST};
      st_r.rst_pend <= 1'b1;
      st_r.pend <= 19'h00001;
      st_r.irq_req <= 1'b1;
      st_r.irq_vec <= VEC_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign reg_rdata = st_r.rdata;
  assign irq_req = st_r.irq_req;
  assign irq_vec = st_r.irq_vec;
  assign wake_req = st_r.wake;
  assign periph_ack = ack_hot & PERIPH_MASK;

  // Checks
  a_vec_in_range: assert property (@(posedge mclk) disable iff (sys_rst)
    irq_req |-> (irq_vec <= VEC_LAST))
    else $error("vector beyond table");

  a_boot_vec_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(sys_rst) |-> (irq_req && irq_vec == VEC_RESET))
    else $error("no reset vector after reset");

  a_level_flag_clr: assert property (@(posedge mclk) disable iff (sys_rst)
    (sense_r == SENSE_LOW) |-> (!st_r.flag_a && !st_r.flag_b))
    else $error("edge flag set in level mode");

  a_fall_sets_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (io_clk_run && sense_r == SENSE_FALL && st_r.ext_p[0] && !st_r.ext_s2[0]
     && !(reg_wr && reg_addr == ADDR_CORE_CTRL)) |=> st_r.flag_a)
    else $error("falling edge lost");

  a_edge_needs_io: assert property (@(posedge mclk) disable iff (sys_rst)
    (!io_clk_run && !st_r.flag_a) |=> !st_r.flag_a)
    else $error("edge seen with I/O clock stopped");

  a_pc_masked_out: assert property (@(posedge mclk) disable iff (sys_rst)
    ((((st_r.pc_s2 ^ st_r.pc_p) & st_r.pc_mask) == 16'h0000) && !st_r.flag_pc) |=> !st_r.flag_pc)
    else $error("masked pin raised pin change flag");

  a_pc_toggle_set: assert property (@(posedge mclk) disable iff (sys_rst)
    (|pc_hit) |=> st_r.flag_pc)
    else $error("enabled toggle lost");

  a_prio_lowest: assert property (@(posedge mclk) disable iff (sys_rst)
    irq_req |-> (st_r.pend[irq_vec] && ((st_r.pend & ((19'h00001 << irq_vec) - 19'h00001)) == 19'h00000)))
    else $error("lower vector pending but not chosen");

  a_ack_clears_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (irq_ack && irq_vec == VEC_EXT_A && !trig_a) |=> !st_r.flag_a)
    else $error("flag survived its vector");

  a_level_request: assert property (@(posedge mclk) disable iff (sys_rst)
    (sense_r == SENSE_LOW && st_r.irq_en[EN_A] && !st_r.ext_s2[0] && $past(glob_irq_en)) |-> st_r.pend[VEC_EXT_A])
    else $error("low level not requesting");

  a_pc_wakes: assert property (@(posedge mclk) disable iff (sys_rst)
    (!io_clk_run && (|pc_hit)) |=> wake_req)
    else $error("pin change did not wake");

  a_cause_restart: assert property (@(posedge mclk) disable iff (sys_rst)
    (|(st_r.rc_s2 & ~st_r.rc_p)) |=> (irq_req && irq_vec == VEC_RESET))
    else $error("reset cause did not request vector zero");

endmodule : vtpi_ctrl
`default_nettype wire

//--- verif/vtpi_core_model.sv
// Core model that takes pending vectors, promptly or after a delay
`timescale 1ns/100ps
`default_nettype none
module vtpi_core_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Vector handshake
  input wire logic irq_req,
  input wire logic hold,
  input wire logic [1:0] dly,
  output logic irq_ack
);
  logic [1:0] cnt_r;
  // Take the vector after dly waiting cycles; hold stalls like masked code
  always_ff @(posedge mclk) begin
    if (sys_rst || !irq_req || hold || irq_ack) begin
      irq_ack <= 1'b0;
      cnt_r <= 2'h0;
    end else if (cnt_r == dly) begin
      irq_ack <= 1'b1; // Handler fetch clears the flag
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
endmodule : vtpi_core_model
`default_nettype wire

//--- verif/vtpi_ctrl_tb_top.sv
// Testbench for the vector and pin interrupt block
`timescale 1ns/100ps
`default_nettype none
module vtpi_ctrl_tb_top;
  import vtpi_pkg::*;
  logic mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, ext_a = 1, ext_b = 1;
  logic glob = 0, io_run = 1, hold = 1, irq_ack, irq_req, wake_req;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [15:0] pcin = 16'h0000;
  logic [3:0] rcause = 4'h0;
  logic [4:0] irq_vec;
  logic [18:0] preq = 19'h00000, pack;
  logic [1:0] dly = 2'h0;
  int num_errors = 0, total_checks = 0;
  logic [4:0] tbl [9] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12};

  vtpi_ctrl i_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .ext_irq_a(ext_a), .ext_irq_b(ext_b),
    .pin_change_inputs(pcin), .reset_cause(rcause), .glob_irq_en(glob), .io_clk_run(io_run),
    .irq_ack(irq_ack), .irq_req(irq_req), .irq_vec(irq_vec), .wake_req(wake_req),
    .periph_req(preq), .periph_ack(pack));
  vtpi_core_model i_core (.mclk(mclk), .sys_rst(sys_rst), .irq_req(irq_req), .hold(hold),
    .dly(dly), .irq_ack(irq_ack));

  // Free-running 4 ns clock
  initial begin
    forever #2 mclk = ~mclk;
  end

  task chk(input logic [18:0] seen, input logic [18:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Settled outputs are sampled mid-cycle; control returns at a rising edge
  task look(input logic wake, input logic [18:0] e);
    @(negedge mclk);
    chk(wake ? 19'(wake_req) : 19'(irq_req), e);
    @(posedge mclk);
  endtask : look
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(19'(rdata), 19'(e));
  endtask : rd
  // Bounded wait for a pending vector, then compare it
  task vec(input logic [4:0] e);
    int i;
    @(negedge mclk);
    for (i = 0; i < 20 && irq_req !== 1'b1; i++) @(negedge mclk);
    chk(19'(irq_req), 19'h00001);
    chk(19'(irq_vec), 19'(e));
  endtask : vec
  task take;
    int i;
    @(posedge mclk) hold <= 1'b0;
    for (i = 0; i < 10 && irq_ack !== 1'b1; i++) @(negedge mclk);
    chk(19'(irq_ack), 19'h00001);
    @(posedge mclk) hold <= 1'b1;
  endtask : take
  task idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle

  // Watchdog against a hung sequence
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end

  initial begin
    int i;
    idle(5);
    sys_rst <= 1'b0;
    vec(VEC_RESET);
    rd(ADDR_CORE_CTRL, 8'h00);
    rd(ADDR_IRQ_EN, 8'h00);
    rd(ADDR_PC_MASK_LO, 8'hC8);
    rd(ADDR_PC_MASK_HI, 8'hFF);
    rd(8'h40, 8'h00);
    take();
    look(1'b0, 19'h00000);
    // Requests with the global enable off never vector
    preq <= 19'h00008;
    idle(2);
    look(1'b0, 19'h00000);
    preq <= 19'h00000;
    glob <= 1'b1;
    // Every timer vector, one at a time, slow core
    dly <= 2'h3;
    for (i = 0; i < 9; i++) begin
      preq <= 19'h1 << tbl[i];
      vec(tbl[i]);
      @(posedge mclk) hold <= 1'b0;
      while (irq_ack !== 1'b1) @(negedge mclk);
      chk(pack, 19'h1 << tbl[i]);
      @(posedge mclk) preq <= 19'h00000;
      hold <= 1'b1;
      idle(3);
    end
    dly <= 2'h0;
    // Two at once: lowest address first
    preq <= 19'h40008;
    vec(VEC_FT_MA);
    take();
    preq <= 19'h40000;
    idle(2);
    vec(VEC_FAULT);
    take();
    preq <= 19'h00000;
    // Pin A falling edge, flag cleared by write-one
    wr(ADDR_CORE_CTRL, 8'h02);
    wr(ADDR_IRQ_EN, 8'h40);
    ext_a <= 1'b0;
    vec(VEC_EXT_A);
    rd(ADDR_IRQ_FLAG, 8'h40);
    wr(ADDR_IRQ_FLAG, 8'h40);
    rd(ADDR_IRQ_FLAG, 8'h00);
    wr(ADDR_CORE_CTRL, 8'h03);
    ext_a <= 1'b1;
    vec(VEC_EXT_A);
    take();
    rd(ADDR_IRQ_FLAG, 8'h00);
    // Low level keeps requesting across a taken vector
    wr(ADDR_CORE_CTRL, 8'h00);
    ext_a <= 1'b0;
    vec(VEC_EXT_A);
    rd(ADDR_IRQ_FLAG, 8'h00);
    take();
    idle(2);
    look(1'b0, 19'h00001);
    ext_a <= 1'b1;
    // Pin B on any change; A released while level mode still holds, so its release leaves no flag
    wr(ADDR_IRQ_EN, 8'h80);
    wr(ADDR_CORE_CTRL, 8'h01);
    ext_b <= 1'b0;
    vec(VEC_EXT_B);
    wr(ADDR_IRQ_FLAG, 8'h80);
    ext_b <= 1'b1;
    vec(VEC_EXT_B);
    wr(ADDR_IRQ_FLAG, 8'h80);
    // Pin change: masked pins 0 and 3, unmasked pins 3 and 9, one from each group
    wr(ADDR_IRQ_EN, 8'h30);
    pcin[0] <= 1'b1;
    idle(8);
    look(1'b0, 19'h00000);
    pcin[3] <= 1'b1;
    vec(VEC_PCHG);
    rd(ADDR_IRQ_FLAG, 8'h20);
    take();
    pcin[9] <= 1'b1;
    vec(VEC_PCHG);
    wr(ADDR_IRQ_FLAG, 8'h20);
    wr(ADDR_PC_MASK_LO, 8'h00);
    pcin[3] <= 1'b0;
    idle(8);
    look(1'b0, 19'h00000);
    // Stopped I/O clock: no edges, but level wakes
    wr(ADDR_CORE_CTRL, 8'h02);
    wr(ADDR_IRQ_EN, 8'h40);
    io_run <= 1'b0;
    ext_a <= 1'b0;
    idle(8);
    rd(ADDR_IRQ_FLAG, 8'h00);
    chk(wake_req, 0);
    wr(ADDR_CORE_CTRL, 8'h00);
    idle(6);
    look(1'b1, 19'h00001);
    // Second reset in mid-run, then pin-change wake
    sys_rst <= 1'b1;
    ext_a <= 1'b1;
    idle(5);
    sys_rst <= 1'b0;
    take();
    wr(ADDR_IRQ_EN, 8'h30);
    pcin[15] <= 1'b1;
    // Pin change wake is a one-cycle pulse, three edges after the pin moves
    idle(3);
    look(1'b1, 19'h00001);
    io_run <= 1'b1;
    wr(ADDR_IRQ_FLAG, 8'h20);
    // Each restart cause asks for vector zero
    for (i = 0; i < 4; i++) begin
      rcause <= 4'h1 << i;
      idle(2);
      vec(VEC_RESET);
      take();
      rcause <= 4'h0;
      idle(4);
    end
    print_verdict();
  end
endmodule : vtpi_ctrl_tb_top
`default_nettype wire
